//--- hw/cpu_opcode_decode_cycles.sv
// Notes on behaviour
// - Opcode 94 takes two cycles, loads stack pointer with index minus one.
// - Opcode 8F clears the interrupt mask, then halts; at least two cycles.
// - A free cycle lasts one clock, needs no bus, shows as a read.
// - Fetch reads next program byte; operand, push and pop cycles move one byte.
// - Vectors are read from the top page, high byte before low byte.
// - Branch offsets are signed, measured from the next instruction's first byte.
// - Direct operands give an 8-bit address with a zero high byte.
// - Bit instructions pick bit 0 to 7, encoded in the opcode.
// - An 8-bit indexed offset is zero-extended and added to the index pair.
// - Indexed no, byte or word offset, and stack byte or word offset modes.
// - Post-increment modes address through the index pair, then increment it.
// - Flags are V, H, I, N, Z, C; the two bits between V and H read one.
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module cpu_opcode_decode_cycles (
    input logic clk,
    input logic rst,
    input logic irq_pin,
    input logic [7:0] bus_rdata,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_write,
    output cpu_pkg::cyc_t cycle_code,
    output logic halted,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import cpu_pkg::*;

    typedef enum logic [3:0] {
        ST_VH, ST_VL, ST_FETCH, ST_PAGE2, ST_OP1, ST_OP2, ST_FREE, ST_READ, ST_WRITE,
        ST_WAIT, ST_PUSH
    } state_t;

    state_t state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, hx_r, hx_nxt, ea_r, ea_nxt, addr_nxt;
    logic [7:0] acc_r, acc_nxt, flg_r, flg_nxt, ir_r, ir_nxt, op1_r, op1_nxt, op2_r, op2_nxt;
    logic [7:0] wd_nxt, flg_rd, dec_op, op1_v, op2_v, rel_v, mask, bset_val;
    logic [15:0] ea, target;
    logic [2:0] cnt_r, cnt_nxt, bitn;
    logic pg2_r, pg2_nxt, wait_pend_r, wait_nxt, launch, wr_nxt, dec_pg2, bit_set;
    logic irq_s1_r, irq_s2_r, soft_irq_r, irq_take, br_ok;
    cyc_t cyc_nxt;
    cls_t cls;
    mode_t mode;
    logic [1:0] nops;
    logic ahb_go, wr_pend_r;
    logic [31:0] wr_addr_r, rd_word;

    function automatic logic [7:0] nz_flags(input logic [7:0] c, input logic [7:0] v);
        logic [7:0] r;
        r = c;
        r[FLG_N] = v[7];
        r[FLG_Z] = (v == ACC_RST);
        r[FLG_V] = 1'b0;
        return r;
    endfunction : nz_flags

    function automatic logic br_cond(input logic [7:0] op, input logic [7:0] c);
        logic b;
        unique case (op[3:1])
            3'h0: b = 1'b1;
            3'h1: b = ~(c[FLG_C] | c[FLG_Z]);
            3'h2: b = ~c[FLG_C];
            3'h3: b = ~c[FLG_Z];
            3'h4: b = ~c[FLG_H];
            3'h5: b = ~c[FLG_N];
            3'h6: b = ~c[FLG_I];
            3'h7: b = 1'b0;
        endcase
        return b ^ op[0];
    endfunction : br_cond

    function automatic logic [7:0] push_byte(input logic [2:0] idx, input logic [15:0] pc,
                                             input logic [15:0] hx, input logic [7:0] a,
                                             input logic [7:0] c);
        logic [7:0] r;
        unique case (idx)
            3'h0: r = pc[7:0];
            3'h1: r = pc[15:8];
            3'h2: r = hx[7:0];
            3'h3: r = a;
            default: r = c;
        endcase
        return r;
    endfunction : push_byte

    // Opcode bytes are decoded in the cycle they arrive, so no extra decode cycle is spent.
    assign dec_op = (state_r == ST_FETCH || state_r == ST_PAGE2) ? bus_rdata : ir_r;
    assign dec_pg2 = (state_r == ST_PAGE2) || (state_r != ST_FETCH && pg2_r);

    op_decode op_decode_inst (
        .opcode(dec_op),
        .page2(dec_pg2),
        .cls(cls),
        .mode(mode),
        .nops(nops),
        .bit_num(bitn),
        .bit_set(bit_set)
    );

    assign flg_rd = flg_r | FLG_ONES;
    assign irq_take = (irq_s2_r | soft_irq_r) & ~flg_r[FLG_I];
    assign op1_v = (state_r == ST_OP1) ? bus_rdata : op1_r;
    assign op2_v = (state_r == ST_OP2) ? bus_rdata : op2_r;
    assign rel_v = (mode == M_REL || mode == M_IXP) ? op1_r : op2_r;
    assign target = pc_r + {{8{rel_v[7]}}, rel_v};
    assign br_ok = br_cond(ir_r, flg_r);
    assign mask = 8'h01 << bitn;
    assign bset_val = bit_set ? (bus_rdata | mask) : (bus_rdata & ~mask);
    assign halted = (state_r == ST_WAIT);

    always_comb begin
        case (mode)
            M_DIR: ea = {DIRECT_PAGE, op1_v};
            M_EXT: ea = {op1_v, op2_v};
            M_IXB, M_IXBP: ea = hx_r + {DIRECT_PAGE, op1_v};
            M_IXW: ea = hx_r + {op1_v, op2_v};
            M_SPB: ea = sp_r + {DIRECT_PAGE, op1_v};
            M_SPW: ea = sp_r + {op1_v, op2_v};
            default: ea = hx_r;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        hx_nxt = hx_r;
        acc_nxt = acc_r;
        flg_nxt = flg_r;
        ir_nxt = ir_r;
        pg2_nxt = pg2_r;
        op1_nxt = op1_r;
        op2_nxt = op2_r;
        ea_nxt = ea_r;
        wd_nxt = bus_wdata;
        cnt_nxt = cnt_r;
        wait_nxt = wait_pend_r;
        launch = 1'b0;
        unique case (state_r)
            ST_VH: begin
                pc_nxt = {bus_rdata, pc_r[7:0]};
                ea_nxt = ea_r + 16'h0001;
                state_nxt = ST_VL;
            end
            ST_VL: begin
                pc_nxt = {pc_r[15:8], bus_rdata};
                state_nxt = ST_FETCH;
            end
            ST_FETCH: begin
                ir_nxt = bus_rdata;
                pg2_nxt = 1'b0;
                if (wait_pend_r) begin
                    wait_nxt = 1'b0;
                    state_nxt = ST_WAIT;
                end else if (irq_take) begin
                    cnt_nxt = PUSH_FIRST;
                    wd_nxt = pc_r[7:0];
                    state_nxt = ST_PUSH;
                end else begin
                    pc_nxt = pc_r + 16'h0001;
                    if (cls == C_PAGE2) begin
                        state_nxt = ST_PAGE2;
                    end else if (nops != OPS_0) begin
                        state_nxt = ST_OP1;
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            ST_PAGE2: begin
                ir_nxt = bus_rdata;
                pg2_nxt = 1'b1;
                pc_nxt = pc_r + 16'h0001;
                if (nops != OPS_0) begin
                    state_nxt = ST_OP1;
                end else begin
                    launch = 1'b1;
                end
            end
            ST_OP1: begin
                op1_nxt = bus_rdata;
                pc_nxt = pc_r + 16'h0001;
                if (nops == OPS_2) begin
                    state_nxt = ST_OP2;
                end else begin
                    launch = 1'b1;
                end
            end
            ST_OP2: begin
                op2_nxt = bus_rdata;
                pc_nxt = pc_r + 16'h0001;
                launch = 1'b1;
            end
            ST_FREE: begin
                state_nxt = ST_FETCH;
                if (cls == C_XTS) begin
                    sp_nxt = hx_r - 16'h0001;
                end else if (cls == C_TSX) begin
                    hx_nxt = sp_r + 16'h0001;
                end else if (cls == C_WAIT) begin
                    flg_nxt[FLG_I] = 1'b0;
                    wait_nxt = 1'b1;
                end else if (cls == C_BRANCH && br_ok) begin
                    pc_nxt = target;
                end
            end
            ST_READ: begin
                state_nxt = ST_FETCH;
                if (cls == C_LDA) begin
                    acc_nxt = bus_rdata;
                    flg_nxt = nz_flags(flg_r, bus_rdata);
                end else if (cls == C_BITSET) begin
                    wd_nxt = bset_val;
                    state_nxt = ST_WRITE;
                end else if (cls == C_BITBR) begin
                    flg_nxt[FLG_C] = bus_rdata[bitn];
                    if (bus_rdata[bitn] == bit_set) begin
                        pc_nxt = target;
                    end
                end else if (cls == C_CBEQ) begin
                    hx_nxt = hx_r + 16'h0001;
                    if (bus_rdata == acc_r) begin
                        pc_nxt = target;
                    end
                end
            end
            ST_WRITE: state_nxt = ST_FETCH;
            ST_WAIT: begin
                // An interrupt leaves this state for the push cycles; reset leaves it through the asynchronous reset.
                if (irq_take) begin
                    cnt_nxt = PUSH_FIRST;
                    wd_nxt = pc_r[7:0];
                    state_nxt = ST_PUSH;
                end
            end
            ST_PUSH: begin
                sp_nxt = sp_r - 16'h0001;
                if (cnt_r == PUSH_LAST) begin
                    flg_nxt[FLG_I] = 1'b1;
                    ea_nxt = {VEC_PAGE, VEC_IRQ_HI};
                    state_nxt = ST_VH;
                end else begin
                    cnt_nxt = cnt_r + 3'h1;
                    wd_nxt = push_byte(cnt_nxt, pc_r, hx_r, acc_r, flg_rd);
                end
            end
        endcase
        if (launch) begin
            state_nxt = ST_FETCH;
            unique case (cls)
                C_NOP, C_PAGE2: ;
                C_CLI: flg_nxt[FLG_I] = 1'b0;
                C_SEI: flg_nxt[FLG_I] = 1'b1;
                C_XTS, C_TSX, C_WAIT, C_BRANCH: state_nxt = ST_FREE;
                C_LDHX: begin
                    hx_nxt = {op1_v, op2_v};
                    flg_nxt = nz_flags(flg_r, op1_v | op2_v);
                    flg_nxt[FLG_N] = op1_v[7];
                end
                C_LDA: begin
                    if (mode == M_IMM) begin
                        acc_nxt = op1_v;
                        flg_nxt = nz_flags(flg_r, op1_v);
                    end else begin
                        ea_nxt = ea;
                        state_nxt = ST_READ;
                    end
                end
                C_BITSET, C_BITBR, C_CBEQ: begin
                    ea_nxt = ea;
                    state_nxt = ST_READ;
                end
                C_STA: begin
                    ea_nxt = ea;
                    wd_nxt = acc_r;
                    flg_nxt = nz_flags(flg_r, acc_r);
                    state_nxt = ST_WRITE;
                end
            endcase
        end
        addr_nxt = pc_nxt;
        wr_nxt = 1'b0;
        cyc_nxt = CYC_PROG;
        unique case (state_nxt)
            ST_FETCH, ST_PAGE2, ST_OP1, ST_OP2: ;
            ST_READ: begin
                addr_nxt = ea_nxt;
                cyc_nxt = CYC_RD;
            end
            ST_WRITE: begin
                addr_nxt = ea_nxt;
                wr_nxt = 1'b1;
                cyc_nxt = CYC_WR;
            end
            ST_FREE, ST_WAIT: cyc_nxt = CYC_FREE;
            ST_PUSH: begin
                addr_nxt = sp_nxt;
                wr_nxt = 1'b1;
                cyc_nxt = CYC_PUSH;
            end
            ST_VH, ST_VL: begin
                addr_nxt = ea_nxt;
                cyc_nxt = CYC_VEC;
            end
        endcase
    end

    // The bus is registered: each state names the cycle now on the bus.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_VH;
            bus_addr <= {VEC_PAGE, VEC_RST_HI};
            bus_wdata <= ACC_RST;
            bus_write <= 1'b0;
            cycle_code <= CYC_VEC;
            ea_r <= {VEC_PAGE, VEC_RST_HI};
        end else begin
            state_r <= state_nxt;
            bus_addr <= addr_nxt;
            bus_wdata <= wd_nxt;
            bus_write <= wr_nxt;
            cycle_code <= cyc_nxt;
            ea_r <= ea_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_r <= PC_RST;
            sp_r <= SP_RST;
            hx_r <= HX_RST;
            acc_r <= ACC_RST;
            flg_r <= FLG_RST;
            ir_r <= ACC_RST;
            pg2_r <= 1'b0;
            op1_r <= ACC_RST;
            op2_r <= ACC_RST;
            cnt_r <= PUSH_FIRST;
            wait_pend_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            hx_r <= hx_nxt;
            acc_r <= acc_nxt;
            flg_r <= flg_nxt;
            ir_r <= ir_nxt;
            pg2_r <= pg2_nxt;
            op1_r <= op1_nxt;
            op2_r <= op2_nxt;
            cnt_r <= cnt_nxt;
            wait_pend_r <= wait_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
        end else begin
            irq_s1_r <= irq_pin;
            irq_s2_r <= irq_s1_r;
        end
    end

    // Zero-wait slave; a write lands at the end of its data phase.
    assign ahb_go = hsel & htrans[HTRANS_ACT_BIT] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        case (haddr)
            REG_CTRL: rd_word = {31'h0000_0000, soft_irq_r};
            REG_STATUS: rd_word = {20'h0_0000, cycle_code, halted, flg_rd};
            REG_HX: rd_word = {16'h0000, hx_r};
            REG_SP: rd_word = {16'h0000, sp_r};
            REG_PC: rd_word = {16'h0000, pc_r};
            REG_ACC: rd_word = {24'h00_0000, acc_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= REG_CTRL;
            hrdata <= 32'h0000_0000;
            soft_irq_r <= 1'b0;
        end else begin
            wr_pend_r <= ahb_go & hwrite;
            if (ahb_go) begin
                wr_addr_r <= haddr;
            end
            if (ahb_go && !hwrite) begin
                hrdata <= rd_word;
            end
            if (wr_pend_r && wr_addr_r == REG_CTRL) begin
                soft_irq_r <= hwdata[CTRL_SOFT_IRQ];
            end
        end
    end

endmodule : cpu_opcode_decode_cycles

//--- hw/cpu_pkg.sv
package cpu_pkg;

    // Opcodes handled by this sequencer.
    localparam logic [7:0] OP_XTS = 8'h94;
    localparam logic [7:0] OP_TSX = 8'h95;
    localparam logic [7:0] OP_WAIT = 8'h8F;
    localparam logic [7:0] OP_PAGE2 = 8'h9E;
    localparam logic [7:0] OP_CLI = 8'h9A;
    localparam logic [7:0] OP_SEI = 8'h9B;
    localparam logic [7:0] OP_LDHX_IMM = 8'h45;
    localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
    localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;

    // Opcode map columns and rows.
    localparam logic [3:0] HI_BITBR = 4'h0;
    localparam logic [3:0] HI_BITSET = 4'h1;
    localparam logic [3:0] HI_BRANCH = 4'h2;
    localparam logic [3:0] HI_IMM = 4'hA;
    localparam logic [3:0] HI_DIR = 4'hB;
    localparam logic [3:0] HI_EXT = 4'hC;
    localparam logic [3:0] HI_IXW = 4'hD;
    localparam logic [3:0] HI_IXB = 4'hE;
    localparam logic [3:0] HI_IX = 4'hF;
    localparam logic [3:0] LO_LDA = 4'h6;
    localparam logic [3:0] LO_STA = 4'h7;
    localparam int BITN_MSB = 3;
    localparam int BITN_LSB = 1;
    localparam int BIT_POL = 0;

    // Operand byte counts.
    localparam logic [1:0] OPS_0 = 2'h0;
    localparam logic [1:0] OPS_1 = 2'h1;
    localparam logic [1:0] OPS_2 = 2'h2;

    // Vectors live in the top page.
    localparam logic [7:0] VEC_PAGE = 8'hFF;
    localparam logic [7:0] VEC_RST_HI = 8'hFE;
    localparam logic [7:0] VEC_IRQ_HI = 8'hFA;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    // Flag positions in the condition flags register.
    localparam int FLG_V = 7;
    localparam int FLG_H = 4;
    localparam int FLG_I = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;
    localparam logic [7:0] FLG_ONES = 8'h60;
    localparam logic [7:0] FLG_RST = 8'h68;

    // Reset values.
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h00FF;
    localparam logic [15:0] HX_RST = 16'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;

    // Exception stacking: PCL, PCH, X, A, flags.
    localparam logic [2:0] PUSH_FIRST = 3'h0;
    localparam logic [2:0] PUSH_LAST = 3'h4;

    // Register bus map.
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_HX = 32'h0000_0008;
    localparam logic [31:0] REG_SP = 32'h0000_000C;
    localparam logic [31:0] REG_PC = 32'h0000_0010;
    localparam logic [31:0] REG_ACC = 32'h0000_0014;
    localparam int CTRL_SOFT_IRQ = 0;
    localparam int HTRANS_ACT_BIT = 1;

    typedef enum logic [2:0] {
        CYC_FREE, CYC_PROG, CYC_RD, CYC_WR, CYC_PUSH, CYC_POP, CYC_VEC
    } cyc_t;

    typedef enum logic [3:0] {
        M_IMP, M_IMM, M_DIR, M_EXT, M_IX, M_IXB, M_IXW, M_IXP, M_IXBP, M_SPB, M_SPW, M_REL
    } mode_t;

    typedef enum logic [3:0] {
        C_NOP, C_XTS, C_TSX, C_WAIT, C_CLI, C_SEI, C_LDHX, C_BRANCH,
        C_BITSET, C_BITBR, C_LDA, C_STA, C_CBEQ, C_PAGE2
    } cls_t;

endpackage : cpu_pkg

//--- hw/op_decode.sv
`timescale 1ns/1ps
module op_decode (
    input logic [7:0] opcode,
    input logic page2,
    output cpu_pkg::cls_t cls,
    output cpu_pkg::mode_t mode,
    output logic [1:0] nops,
    output logic [2:0] bit_num,
    output logic bit_set
);
    import cpu_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    always_comb begin
        cls = C_NOP;
        mode = M_IMP;
        nops = OPS_0;
        bit_num = opcode[BITN_MSB:BITN_LSB];
        bit_set = ~opcode[BIT_POL];
        if (page2) begin
            if ((lo == LO_LDA || lo == LO_STA) && (hi == HI_IXW || hi == HI_IXB)) begin
                cls = (lo == LO_LDA) ? C_LDA : C_STA;
                mode = (hi == HI_IXW) ? M_SPW : M_SPB;
                nops = (hi == HI_IXW) ? OPS_2 : OPS_1;
            end
        end else if (hi == HI_BITBR) begin
            cls = C_BITBR;
            mode = M_DIR;
            nops = OPS_2;
        end else if (hi == HI_BITSET) begin
            cls = C_BITSET;
            mode = M_DIR;
            nops = OPS_1;
        end else if (hi == HI_BRANCH) begin
            cls = C_BRANCH;
            mode = M_REL;
            nops = OPS_1;
        end else if (opcode == OP_CBEQ_IXP) begin
            cls = C_CBEQ;
            mode = M_IXP;
            nops = OPS_1;
        end else if (opcode == OP_CBEQ_IX1P) begin
            cls = C_CBEQ;
            mode = M_IXBP;
            nops = OPS_2;
        end else if (opcode == OP_LDHX_IMM) begin
            cls = C_LDHX;
            mode = M_IMM;
            nops = OPS_2;
        end else if (opcode == OP_XTS) begin
            cls = C_XTS;
        end else if (opcode == OP_TSX) begin
            cls = C_TSX;
        end else if (opcode == OP_WAIT) begin
            cls = C_WAIT;
        end else if (opcode == OP_CLI) begin
            cls = C_CLI;
        end else if (opcode == OP_SEI) begin
            cls = C_SEI;
        end else if (opcode == OP_PAGE2) begin
            cls = C_PAGE2;
        end else if (hi >= HI_IMM && (lo == LO_LDA || (lo == LO_STA && hi != HI_IMM))) begin
            cls = (lo == LO_LDA) ? C_LDA : C_STA;
            unique case (hi)
                HI_IMM: begin
                    mode = M_IMM;
                    nops = OPS_1;
                end
                HI_DIR: begin
                    mode = M_DIR;
                    nops = OPS_1;
                end
                HI_EXT: begin
                    mode = M_EXT;
                    nops = OPS_2;
                end
                HI_IXW: begin
                    mode = M_IXW;
                    nops = OPS_2;
                end
                HI_IXB: begin
                    mode = M_IXB;
                    nops = OPS_1;
                end
                default: begin
                    mode = M_IX;
                    nops = OPS_0;
                end
            endcase
        end
    end

endmodule : op_decode

//--- verif/cpu_mem_model.sv
`timescale 1ns/1ps
module cpu_mem_model (
    input logic clk,
    input logic [15:0] bus_addr,
    input logic [7:0] bus_wdata,
    input logic bus_write,
    output logic [7:0] bus_rdata
);
    logic [7:0] mem [0:65535];
    // Unused space holds a no-op, so a stray fetch cannot derail the run.
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h9D;
    // Nothing answers a write cycle, so the line shows garbage then.
    assign bus_rdata = bus_write ? ~mem[bus_addr] : mem[bus_addr];
    always @(posedge clk) begin
        if (bus_write) mem[bus_addr] <= bus_wdata;
    end
endmodule : cpu_mem_model

//--- verif/cpu_opcode_decode_cycles_checker.sv
`timescale 1ns/1ps
module cpu_opcode_decode_cycles_checker (
    input logic clk,
    input logic rst,
    input logic irq_pin,
    input logic [15:0] bus_addr,
    input logic bus_write,
    input cpu_pkg::cyc_t cycle_code,
    input logic halted
);
    import cpu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_free_read: assert property (cycle_code == CYC_FREE |-> !bus_write)
        else $error("free cycle drives a write");
    a_write_kind: assert property (bus_write |-> cycle_code inside {CYC_WR, CYC_PUSH})
        else $error("write outside a write or push cycle");
    a_push_write: assert property (cycle_code == CYC_PUSH |-> bus_write)
        else $error("push cycle is not a write");
    a_prog_next: assert property (cycle_code == CYC_PROG ##1 cycle_code == CYC_PROG
        |-> bus_addr == $past(bus_addr) + 16'h1) else $error("fetch skipped a location");
    a_vec_page: assert property (cycle_code == CYC_VEC |-> bus_addr[15:8] == VEC_PAGE)
        else $error("vector read off the top page");
    a_vec_order: assert property (cycle_code == CYC_VEC && !bus_addr[0] |=>
        cycle_code == CYC_VEC && bus_addr == $past(bus_addr) + 16'h1)
        else $error("vector low byte does not follow high byte");
    a_halt_free: assert property (halted |-> cycle_code == CYC_FREE && !bus_write)
        else $error("bus used while stalled");
    a_halt_holds: assert property ((halted && !irq_pin)[*3] |=> halted)
        else $error("stall left without interrupt");
    a_wake_push: assert property (halted && irq_pin |-> ##[1:6] cycle_code == CYC_PUSH)
        else $error("no stacking after wake");
    c_halt: cover property (halted ##1 !halted);
    c_vec: cover property (cycle_code == CYC_VEC && bus_addr == 16'hFFFA);
    c_wr: cover property (cycle_code == CYC_WR);
endmodule : cpu_opcode_decode_cycles_checker

//--- verif/cpu_opcode_decode_cycles_tb_top.sv
`timescale 1ns/1ps
module cpu_opcode_decode_cycles_tb_top;
    import cpu_pkg::*;
    logic clk, rst, irq_pin, hwrite, bus_write, halted, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] bus_addr;
    logic [7:0] bus_rdata, bus_wdata;
    cyc_t cycle_code;
    int n_mismatch = 0, checked = 0, cyc = 0, t94 = 0, t95 = 0;
    logic [7:0] prog [0:15] = '{8'h45, 8'h12, 8'h34, 8'h94, 8'hE6, 8'hF0, 8'hB7, 8'h40,
        8'h16, 8'h40, 8'h20, 8'h02, 8'hB7, 8'h41, 8'h8F, 8'h9D};
    logic [7:0] hnd [0:6] = '{8'h9E, 8'hE6, 8'h05, 8'h71, 8'h00, 8'h20, 8'hFE};
    cpu_opcode_decode_cycles cpu_opcode_decode_cycles_inst (.clk(clk), .rst(rst),
        .irq_pin(irq_pin), .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .cycle_code(cycle_code), .halted(halted), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    cpu_mem_model cpu_mem_model_inst (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_rdata(bus_rdata));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wait_prog(input logic [15:0] a);
        repeat (60) if (!(cycle_code === CYC_PROG && bus_addr === a)) @(negedge clk);
        check("fetch address", {16'h0, bus_addr}, {16'h0, a});
    endtask : wait_prog
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // The ceiling of 4000 cycles is more than ten times the length of the whole program run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end
    always @(negedge clk) begin
        if (cycle_code === CYC_PROG && bus_addr === 16'h0103) t94 = cyc;
        if (cycle_code === CYC_PROG && bus_addr === 16'h0104) t95 = cyc;
    end
    initial begin
        rst = 1'b1;
        irq_pin = 1'b0;
        htrans = 2'h0;
        haddr = '0;
        hwrite = 1'b0;
        hwdata = '0;
        @(posedge clk);
        for (int i = 0; i < 16; i++) cpu_mem_model_inst.mem[16'h0100 + i] = prog[i];
        cpu_mem_model_inst.mem[16'hFFFE] = 8'h01;
        cpu_mem_model_inst.mem[16'hFFFF] = 8'h00;
        cpu_mem_model_inst.mem[16'hFFFA] = 8'h03;
        cpu_mem_model_inst.mem[16'hFFFB] = 8'h00;
        for (int i = 0; i < 7; i++) cpu_mem_model_inst.mem[16'h0300 + i] = hnd[i];
        cpu_mem_model_inst.mem[16'h1324] = 8'hA5;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (200) if (halted !== 1'b1) @(posedge clk);
        check("halted", {31'h0, halted}, 32'h1);
        check("transfer cycles", 32'(t95 - t94), 32'h2);
        bus(REG_SP, 1'b0, '0);
        check("stack pointer", rd, 32'h1233);
        bus(REG_STATUS, 1'b0, '0);
        check("status", rd, 32'h164);
        check("bit set", {24'h0, cpu_mem_model_inst.mem[16'h0040]}, 32'hAD);
        check("bit three", {31'h0, cpu_mem_model_inst.mem[16'h0040][3]}, 32'h1);
        check("skipped store", {24'h0, cpu_mem_model_inst.mem[16'h0041]}, 32'h9D);
        $display("test program done");
        irq_pin <= 1'b1;
        wait_prog(16'h0300);
        check("stacked", {cpu_mem_model_inst.mem[16'h1230], cpu_mem_model_inst.mem[16'h1231],
            cpu_mem_model_inst.mem[16'h1232], cpu_mem_model_inst.mem[16'h1233]},
            32'hA534010F);
        @(posedge clk);
        irq_pin <= 1'b0;
        repeat (10) @(negedge clk);
        wait_prog(16'h0305);
        $display("test wake done");
        @(posedge clk);
        bus(REG_CTRL, 1'b1, 32'h1);
        @(posedge clk);
        bus(REG_CTRL, 1'b0, '0);
        check("control", rd, 32'h1);
        bus(32'h20, 1'b0, '0);
        check("unmapped", rd, 32'h0);
        bus(REG_HX, 1'b0, '0);
        check("index pair", rd, 32'h1235);
        bus(REG_ACC, 1'b0, '0);
        check("accumulator", rd, 32'h0F);
        check("response", {31'h0, hresp}, 32'h0);
        bus(REG_CTRL, 1'b1, 32'h0);
        $display("test registers done");
        stop_test();
    end
endmodule : cpu_opcode_decode_cycles_tb_top
bind cpu_opcode_decode_cycles cpu_opcode_decode_cycles_checker
    cpu_opcode_decode_cycles_checker_inst (.clk(clk), .rst(rst), .irq_pin(irq_pin),
    .bus_addr(bus_addr), .bus_write(bus_write), .cycle_code(cycle_code), .halted(halted));
